// >>> hw/cmd_decode_pkg.sv
// How it works
// - Fieldbus word copied as is into internal bits 0 to 15; bits 16 up unused.
// - Bit 0 set requests a stop, bit 1 set requests a start; zero does nothing.
// - Forward when sign positive with bit 2 clear, or negative with bit 2 set.
// - Fault reset only on a rising bit 4 while a fault is active.
// - With fieldbus location choice, bit 5 set picks second location, clear picks first.
// - With fieldbus run permission, bit 6 set withdraws it, clear grants it.
// - Bits 7, 8, 9 request normal ramp, emergency ramp and coast stop.
// - With bits 7 to 9 all clear, the configured stop mode applies.
// - Bit 11 set forces the ramp generator output to zero.
// - Bit 12 set freezes the ramp generator output at its present value.
package cmd_decode_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] CMD_OFS = 8'h00;
    localparam logic [7:0] CFG_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] INTERNAL_OFS = 8'h0c;

    localparam logic [15:0] CMD_RESET = 16'h0000;
    localparam logic [3:0] CFG_RESET = 4'h0;

    // ************************************************************
    // Command word fields
    // ************************************************************
    localparam int BIT_STOP = 0;
    localparam int BIT_START = 1;
    localparam int BIT_REVERSE = 2;
    localparam int BIT_FAULT_RESET = 4;
    localparam int BIT_SECOND_LOCATION = 5;
    localparam int BIT_RUN_DISABLE = 6;
    localparam int BIT_NORMAL_RAMP_STOP = 7;
    localparam int BIT_EMERGENCY_RAMP_STOP = 8;
    localparam int BIT_COAST_STOP = 9;
    localparam int BIT_RAMP_OUT_ZERO = 11;
    localparam int BIT_RAMP_HOLD = 12;

    // Bits 3 and 10 carry no function and are masked before decoding.
    localparam logic [15:0] CMD_USED_MASK = 16'hfbf7;

    // ************************************************************
    // Configuration fields
    // ************************************************************
    localparam int CFG_LOC_FB_BIT = 0;
    localparam int CFG_RUN_FB_BIT = 1;
    localparam int CFG_STOPMODE_LSB = 2;

    localparam logic [1:0] PARAM_STOP_RAMP = 2'h0;
    localparam logic [1:0] PARAM_STOP_EMERGENCY = 2'h1;
    localparam logic [1:0] PARAM_STOP_COAST = 2'h2;

    // ************************************************************
    // Status fields
    // ************************************************************
    localparam int ST_STOP = 0;
    localparam int ST_START = 1;
    localparam int ST_REVERSE = 2;
    localparam int ST_SECOND_LOCATION = 3;
    localparam int ST_RUN_ENABLE = 4;
    localparam int ST_RAMP_OUT_ZERO = 5;
    localparam int ST_RAMP_HOLD = 6;
    localparam int ST_FAULT_ACTIVE = 7;
    localparam int ST_STOP_MODE_LSB = 8;

    typedef enum logic [2:0] {
        STOP_NORMAL_RAMP = 3'h1,
        STOP_EMERGENCY_RAMP = 3'h2,
        STOP_COAST = 3'h4
    } stop_mode_t;

endpackage : cmd_decode_pkg

// >>> hw/rise_pulse.sv
module rise_pulse
    import cmd_decode_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic level_in,
    input wire logic qualify_in,
    output logic pulse_out
);

    typedef struct packed {
        logic prev;
        logic pulse;
    } edge_state_t;

    edge_state_t state;
    edge_state_t next_state;

    always_comb begin
        next_state = state;
        next_state.prev = level_in;
        // A level that stays high gives one pulse only.
        next_state.pulse = level_in & ~state.prev & qualify_in;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign pulse_out = state.pulse;

endmodule : rise_pulse

// >>> hw/stop_mode_select.sv
module stop_mode_select
    import cmd_decode_pkg::*;
(
    input wire logic normal_ramp_stop_request_in,
    input wire logic emergency_ramp_stop_request_in,
    input wire logic coast_stop_request_in,
    input wire logic [1:0] param_stop_mode_in,
    output stop_mode_t stop_mode_out
);

    // Several requests at once are a master fault; the hardest stop wins for safety.
    always_comb begin
        if (coast_stop_request_in) begin
            stop_mode_out = STOP_COAST;
        end else if (emergency_ramp_stop_request_in) begin
            stop_mode_out = STOP_EMERGENCY_RAMP;
        end else if (normal_ramp_stop_request_in) begin
            stop_mode_out = STOP_NORMAL_RAMP;
        end else begin
            unique case (param_stop_mode_in)
                PARAM_STOP_EMERGENCY: stop_mode_out = STOP_EMERGENCY_RAMP;
                PARAM_STOP_COAST: stop_mode_out = STOP_COAST;
                default: stop_mode_out = STOP_NORMAL_RAMP;
            endcase
        end
    end

endmodule : stop_mode_select

// >>> hw/fieldbus_control_word_decoder.sv
// The plain strobed port and the register offsets were decided locally.
module fieldbus_control_word_decoder
    import cmd_decode_pkg::*;
#(
    parameter int ADDR_WIDTH = 8
) (
    input wire logic SYS_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic [ADDR_WIDTH-1:0] ADDR_IN,
    input wire logic [31:0] WDATA_IN,
    input wire logic WRITE_IN,
    input wire logic READ_IN,
    output logic [31:0] RDATA_OUT,
    input wire logic REF_NEGATIVE_IN,
    input wire logic FAULT_ACTIVE_IN,
    input wire logic SECOND_LOCATION_LOCAL_IN,
    input wire logic RUN_ENABLE_LOCAL_IN,
    output logic [31:0] INTERNAL_COMMAND_OUT,
    output logic STOP_OUT,
    output logic START_OUT,
    output logic [2:0] STOP_MODE_OUT,
    output logic REVERSE_OUT,
    output logic FAULT_RESET_OUT,
    output logic SECOND_LOCATION_OUT,
    output logic RUN_ENABLE_OUT,
    output logic RAMP_OUT_ZERO_OUT,
    output logic RAMP_HOLD_OUT
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    if (ADDR_WIDTH < 4 || ADDR_WIDTH > 8) begin : g_bad_addr
        $error("ADDR_WIDTH must lie between 4 and 8");
    end

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [15:0] cmd;
        logic [3:0] cfg;
        logic [31:0] rdata;
        logic stop;
        logic start;
        logic [2:0] stop_mode;
        logic reverse;
        logic second_location;
        logic run_enable;
        logic ramp_out_zero;
        logic ramp_hold;
    } dec_state_t;

    dec_state_t state;
    dec_state_t next_state;

    logic [7:0] addr;
    logic [15:0] used_cmd;
    logic [31:0] internal_cmd;
    logic [31:0] status_word;
    stop_mode_t resolved_mode;
    logic fault_reset_pulse;

    // A narrow address is zero-extended so the map keeps its byte offsets.
    assign addr = 8'(ADDR_IN);

    // The upper half of the internal word has no meaning under this profile.
    assign internal_cmd = {16'h0000, state.cmd};

    // Bits 3 and 10 are cleared before any decoding looks at them; bits 13 to 15 pass unmasked.
    assign used_cmd = state.cmd & CMD_USED_MASK;

    // ************************************************************
    // Helpers
    // ************************************************************
    stop_mode_select u_stop_mode (
        .normal_ramp_stop_request_in(used_cmd[BIT_NORMAL_RAMP_STOP]),
        .emergency_ramp_stop_request_in(used_cmd[BIT_EMERGENCY_RAMP_STOP]),
        .coast_stop_request_in(used_cmd[BIT_COAST_STOP]),
        .param_stop_mode_in(state.cfg[CFG_STOPMODE_LSB +: 2]),
        .stop_mode_out(resolved_mode)
    );

    rise_pulse u_fault_reset (
        .clk_in(SYS_CLK_IN),
        .rst_n_in(RST_N_IN),
        .level_in(used_cmd[BIT_FAULT_RESET]),
        .qualify_in(FAULT_ACTIVE_IN),
        .pulse_out(fault_reset_pulse)
    );

    // ************************************************************
    // Status view
    // ************************************************************
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[ST_STOP] = state.stop;
        status_word[ST_START] = state.start;
        status_word[ST_REVERSE] = state.reverse;
        status_word[ST_SECOND_LOCATION] = state.second_location;
        status_word[ST_RUN_ENABLE] = state.run_enable;
        status_word[ST_RAMP_OUT_ZERO] = state.ramp_out_zero;
        status_word[ST_RAMP_HOLD] = state.ramp_hold;
        status_word[ST_FAULT_ACTIVE] = FAULT_ACTIVE_IN;
        status_word[ST_STOP_MODE_LSB +: 3] = state.stop_mode;
    end

    // ************************************************************
    // Register bus and decoding
    // ************************************************************
    always_comb begin
        next_state = state;
        next_state.rdata = 32'h0000_0000;

        if (WRITE_IN) begin
            unique case (addr)
                CMD_OFS: next_state.cmd = WDATA_IN[15:0];
                CFG_OFS: next_state.cfg = WDATA_IN[3:0];
                default: next_state.cmd = state.cmd;
            endcase
        end

        if (READ_IN) begin
            unique case (addr)
                CMD_OFS: next_state.rdata = {16'h0000, state.cmd};
                CFG_OFS: next_state.rdata = {28'h000_0000, state.cfg};
                STATUS_OFS: next_state.rdata = status_word;
                INTERNAL_OFS: next_state.rdata = internal_cmd;
                default: next_state.rdata = 32'h0000_0000;
            endcase
        end

        // A word holding both requests stops: stopping is the safe reading.
        next_state.stop = used_cmd[BIT_STOP];
        next_state.start = used_cmd[BIT_START] & ~used_cmd[BIT_STOP];
        next_state.stop_mode = resolved_mode;
        next_state.reverse = used_cmd[BIT_REVERSE] ^ REF_NEGATIVE_IN;

        if (state.cfg[CFG_LOC_FB_BIT]) begin
            next_state.second_location = used_cmd[BIT_SECOND_LOCATION];
        end else begin
            next_state.second_location = SECOND_LOCATION_LOCAL_IN;
        end

        if (state.cfg[CFG_RUN_FB_BIT]) begin
            next_state.run_enable = ~used_cmd[BIT_RUN_DISABLE];
        end else begin
            next_state.run_enable = RUN_ENABLE_LOCAL_IN;
        end

        next_state.ramp_out_zero = used_cmd[BIT_RAMP_OUT_ZERO];
        next_state.ramp_hold = used_cmd[BIT_RAMP_HOLD];
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state <= '0;
            state.cmd <= CMD_RESET;
            state.cfg <= CFG_RESET;
            state.stop_mode <= STOP_NORMAL_RAMP;
        end else begin
            state <= next_state;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign RDATA_OUT = state.rdata;
    assign INTERNAL_COMMAND_OUT = internal_cmd;
    assign STOP_OUT = state.stop;
    assign START_OUT = state.start;
    assign STOP_MODE_OUT = state.stop_mode;
    assign REVERSE_OUT = state.reverse;
    assign FAULT_RESET_OUT = fault_reset_pulse;
    assign SECOND_LOCATION_OUT = state.second_location;
    assign RUN_ENABLE_OUT = state.run_enable;
    assign RAMP_OUT_ZERO_OUT = state.ramp_out_zero;
    assign RAMP_HOLD_OUT = state.ramp_hold;

endmodule : fieldbus_control_word_decoder

// >>> test/decoder_props.sv
module decoder_props
    import cmd_decode_pkg::*;
#(
    parameter int ADDR_WIDTH = 8
) (
    input wire logic SYS_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic [ADDR_WIDTH-1:0] ADDR_IN,
    input wire logic [31:0] WDATA_IN,
    input wire logic WRITE_IN,
    input wire logic REF_NEGATIVE_IN,
    input wire logic FAULT_ACTIVE_IN,
    input wire logic [31:0] INTERNAL_COMMAND_OUT,
    input wire logic STOP_OUT,
    input wire logic START_OUT,
    input wire logic [2:0] STOP_MODE_OUT,
    input wire logic REVERSE_OUT,
    input wire logic FAULT_RESET_OUT,
    input wire logic RAMP_OUT_ZERO_OUT,
    input wire logic RAMP_HOLD_OUT
);
    // ****************************************
    // Decoded outputs trail the word by one edge
    // ****************************************
    default clocking @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    wire logic [15:0] cw = INTERNAL_COMMAND_OUT[15:0];
    AST_COPY: assert property (
        WRITE_IN && ADDR_IN == CMD_OFS |=> cw == $past(WDATA_IN[15:0])) else $error("copy");
    AST_UPPER: assert property (INTERNAL_COMMAND_OUT[31:16] == 16'h0000) else $error("upper");
    AST_STOP: assert property (1'b1 |=> STOP_OUT == $past(cw[0])) else $error("stop");
    AST_START: assert property (
        1'b1 |=> START_OUT == $past(cw[1] & ~cw[0])) else $error("start");
    AST_DIR: assert property (
        1'b1 |=> REVERSE_OUT == $past(cw[2] ^ REF_NEGATIVE_IN)) else $error("direction");
    AST_PULSE: assert property (
        $rose(cw[4]) && FAULT_ACTIVE_IN |=> FAULT_RESET_OUT ##1 !FAULT_RESET_OUT) else $error("pulse");
    AST_NO_PULSE: assert property (
        FAULT_RESET_OUT |-> $past(FAULT_ACTIVE_IN) && $past(cw[4]) && !$past(cw[4], 2))
        else $error("stray pulse");
    AST_MODE: assert property (|cw[9:7] |=> STOP_MODE_OUT ==
        ($past(cw[9]) ? 3'h4 : $past(cw[8]) ? 3'h2 : 3'h1)) else $error("mode");
    AST_ZERO: assert property (1'b1 |=> RAMP_OUT_ZERO_OUT == $past(cw[11])) else $error("zero");
    AST_HOLD: assert property (1'b1 |=> RAMP_HOLD_OUT == $past(cw[12])) else $error("hold");
endmodule : decoder_props

// >>> test/fieldbus_master_model.sv
module fieldbus_master_model (
    input wire logic clk_in,
    input wire logic [31:0] rdata_in,
    output logic [7:0] addr_out,
    output logic [31:0] wdata_out,
    output logic write_out,
    output logic read_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        addr_out = 8'h00;
        wdata_out = 32'h0000_0000;
        write_out = 1'b0;
        read_out = 1'b0;
    end
    // Released lines show the inverse so a stale value never looks valid.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_out <= a;
        wdata_out <= d;
        write_out <= 1'b1;
        @(posedge clk_in);
        write_out <= 1'b0;
        addr_out <= ~a;
        wdata_out <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_in);
        addr_out <= a;
        read_out <= 1'b1;
        @(posedge clk_in);
        read_out <= 1'b0;
        addr_out <= ~a;
        #1;
        d = rdata_in;
    endtask : rd
endmodule : fieldbus_master_model

// >>> test/fieldbus_control_word_decoder_tb.sv
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
    $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module fieldbus_control_word_decoder_tb
    import cmd_decode_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst_n, wr_s, rd_s, ref_neg, fault, loc_l, run_l;
    logic stop, start, rev, fres, loc, run, rz, rh;
    logic [2:0] mode;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, icmd, rv;
    int error_cnt = 0;
    int samples_checked = 0;
    fieldbus_control_word_decoder i_fieldbus_control_word_decoder (
        .SYS_CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WRITE_IN(wr_s), .READ_IN(rd_s), .RDATA_OUT(rdata), .REF_NEGATIVE_IN(ref_neg),
        .FAULT_ACTIVE_IN(fault), .SECOND_LOCATION_LOCAL_IN(loc_l), .RUN_ENABLE_LOCAL_IN(run_l),
        .INTERNAL_COMMAND_OUT(icmd), .STOP_OUT(stop), .START_OUT(start), .STOP_MODE_OUT(mode),
        .REVERSE_OUT(rev), .FAULT_RESET_OUT(fres), .SECOND_LOCATION_OUT(loc),
        .RUN_ENABLE_OUT(run), .RAMP_OUT_ZERO_OUT(rz), .RAMP_HOLD_OUT(rh));
    fieldbus_master_model i_fieldbus_master_model (.clk_in(clk), .rdata_in(rdata),
        .addr_out(addr), .wdata_out(wdata), .write_out(wr_s), .read_out(rd_s));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic test_done;
        if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done
    // Decoded outputs settle one edge after the command register takes the write.
    task automatic put(input logic [15:0] c);
        i_fieldbus_master_model.wr(CMD_OFS, {16'h0000, c});
        @(posedge clk);
        #1;
    endtask : put
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        test_done();
    end
    initial begin
        rst_n = 1'b0;
        ref_neg = 1'b0;
        fault = 1'b0;
        loc_l = 1'b1;
        run_l = 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        `CHK(mode, 3'h1)
        i_fieldbus_master_model.rd(8'h10, rv);
        `CHK(rv, 32'h0000_0000)
        i_fieldbus_master_model.wr(CMD_OFS, 32'habcd_1234);
        #1;
        `CHK(icmd, 32'h0000_1234)
        i_fieldbus_master_model.wr(INTERNAL_OFS, 32'hffff_ffff);
        i_fieldbus_master_model.rd(INTERNAL_OFS, rv);
        `CHK(rv, 32'h0000_1234)
        for (int i = 0; i < 4; i++) begin
            put(16'(i));
            `CHK(stop, i[0])
            `CHK(start, i[1] & ~i[0])
            @(posedge clk);
            ref_neg <= i[1];
            put(i[0] ? 16'h0004 : 16'h0000);
            `CHK(rev, i[0] ^ i[1])
            i_fieldbus_master_model.wr(CFG_OFS, 32'(i) << 2);
            put(16'h0000);
            `CHK(mode, i == 3 ? 3'h1 : 3'h1 << i)
        end
        for (int i = 0; i < 3; i++) begin
            put(16'h0080 << i);
            `CHK(mode, 3'h1 << i)
        end
        i_fieldbus_master_model.wr(CFG_OFS, 32'h0000_0003);
        put(16'h0020);
        `CHK({loc, run}, 2'h3)
        put(16'h0040);
        `CHK({loc, run}, 2'h0)
        i_fieldbus_master_model.rd(CMD_OFS, rv);
        `CHK(rv, 32'h0000_0040)
        i_fieldbus_master_model.rd(CFG_OFS, rv);
        `CHK(rv, 32'h0000_0003)
        i_fieldbus_master_model.rd(STATUS_OFS, rv);
        `CHK(rv, 32'h0000_0104)
        @(posedge clk);
        #1;
        `CHK(rdata, 32'h0000_0000)
        i_fieldbus_master_model.wr(CFG_OFS, 32'h0000_0000);
        put(16'h0800);
        `CHK({loc, run, rz, rh}, 4'ha)
        put(16'h1000);
        `CHK({rz, rh}, 2'h1)
        put(16'h0408);
        `CHK({stop, start, rev, loc, run, rz, rh, fres, mode}, 11'h181)
        put(16'h0010);
        `CHK(fres, 1'b0)
        put(16'h0000);
        @(posedge clk);
        fault <= 1'b1;
        put(16'h0010);
        `CHK(fres, 1'b1)
        @(posedge clk);
        #1;
        `CHK(fres, 1'b0)
        put(16'h0010);
        `CHK(fres, 1'b0)
        test_done();
    end
endmodule : fieldbus_control_word_decoder_tb
bind fieldbus_control_word_decoder decoder_props #(.ADDR_WIDTH(ADDR_WIDTH)) i_decoder_props (
    .SYS_CLK_IN(SYS_CLK_IN), .RST_N_IN(RST_N_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN),
    .WRITE_IN(WRITE_IN), .REF_NEGATIVE_IN(REF_NEGATIVE_IN), .FAULT_ACTIVE_IN(FAULT_ACTIVE_IN),
    .INTERNAL_COMMAND_OUT(INTERNAL_COMMAND_OUT), .STOP_OUT(STOP_OUT), .START_OUT(START_OUT),
    .STOP_MODE_OUT(STOP_MODE_OUT), .REVERSE_OUT(REVERSE_OUT), .FAULT_RESET_OUT(FAULT_RESET_OUT),
    .RAMP_OUT_ZERO_OUT(RAMP_OUT_ZERO_OUT), .RAMP_HOLD_OUT(RAMP_HOLD_OUT));
